//--- verilog/acu_params.svh
// accumulator access unit constants: field positions, sizes, limit values
// assumes inclusion by the design module only
`ifndef ACU_PARAMS_SVH
`define ACU_PARAMS_SVH
`define ACU_NUM_ACC 4
`define ACU_ACC_W 36
`define ACU_EXT_MSB 35
`define ACU_EXT_LSB 32
`define ACU_HI_MSB 31
`define ACU_HI_LSB 16
`define ACU_LO_MSB 15
`define ACU_LO_LSB 0
`define ACU_POS_LIMIT 16'h7fff
`define ACU_NEG_LIMIT 16'h8000
`define ACU_ACC_RESET 36'h0_0000_0000
`endif

//--- verilog/acu_pkg.sv
// accumulator access unit types: access targets, sizes and the request struct
// assumes the decoder drives one request per cycle
package acu_pkg;
    typedef enum logic [2:0] {
        ACU_SEL_WHOLE,
        ACU_SEL_LONG_PAIR,
        ACU_SEL_EXT,
        ACU_SEL_HIGH,
        ACU_SEL_LOW
    } acu_sel_t;
    typedef enum logic [1:0] {
        ACU_SIZE_BYTE,
        ACU_SIZE_WORD,
        ACU_SIZE_LONG
    } acu_size_t;
    typedef struct packed {
        logic valid;
        logic write;
        logic [1:0] acc;
        acu_sel_t sel;
        acu_size_t size;
        logic unsigned_move;
        logic [31:0] data;
    } acu_req_t;
    typedef struct packed {
        logic valid;
        logic [1:0] acc;
        logic [35:0] value;
    } acu_alu_wr_t;
endpackage

//--- verilog/acu_core.sv
// accumulator access unit: four accumulators with whole, pair and portion access
// assumes decoded move requests and alu results are synchronous to core_clk
//
// Functional notes
// - four 36-bit accumulators, whole, long pair and portion access
// - whole accumulator stored as source is limited on overflow
// - long pair read returns 32 bits with no limiting
// - portion reads and writes are never limited
// - third and fourth accumulators refuse extension and low portion moves
// - word read of whole returns high word when extension unused
// - word read of whole returns limited value when extension in use
// - arithmetic operand output carries all 36 bits unlimited
// - word write to whole: high word, sign extension, low cleared
// - byte write to whole: low byte, sign or zero fill, low cleared
// - long write to whole: 32 bits into pair, extension sign filled
// - long pair refused as write destination
// - extension word read is sign extended to 16 bits
// - extension word write keeps 4 low bits only, others untouched
// - high word read gives 16 bits, byte read gives low 8
// - high word is the 16-bit operand for arithmetic and unsigned moves
// - high word write replaces only those 16 bits
// - low word read of first two accumulators returns 16 bits
// - low word write replaces only those 16 bits
// - layout: extension 35..32, high 31..16, low 15..0
// - extension in use flag set when an alu result crosses bit 31
// - limiting gives 7fff or 8000, or 7fffffff or 80000000 on long reads, source accumulator unchanged
// - limit flag set whenever a transferred value is limited
`timescale 1ns/1ps
`include "acu_params.svh"

module acu_core (
    input wire logic core_clk,
    input wire logic rstn,
    input wire acu_pkg::acu_req_t req,
    input wire acu_pkg::acu_alu_wr_t alu_wr,
    input wire logic [1:0] operand_sel,
    output logic [31:0] core_read_data_bus,
    output logic read_valid,
    output logic req_refused,
    output logic [35:0] alu_operand_whole,
    output logic [15:0] alu_operand_high,
    output logic ext_in_use,
    output logic limit_flag
);
    logic [35:0] acc_reg [0:3];
    logic [35:0] cur;
    logic [3:0] ext;
    logic [15:0] hi;
    logic [15:0] lo;
    logic [31:0] pair_rd;
    logic [11:0] ext_fill;

    logic in_use;
    logic [15:0] limited;
    logic [15:0] lim_lo;
    logic size_byte;
    logic size_word;
    logic size_long;

    logic portion_blocked;
    logic pair_write;
    logic refuse;
    logic do_read;
    logic do_write;

    logic [31:0] whole_rd;
    logic whole_lim;
    logic [31:0] rd_next;
    logic lim_hit;

    logic byte_fill;
    logic [35:0] whole_wr;
    logic [35:0] wr_val;
    logic [3:0] mv_hit;
    logic [3:0] alu_hit;
    logic res_in_use;

    // current accumulator fields
    // field layout
    assign cur = acc_reg[req.acc];
    assign ext = cur[`ACU_EXT_MSB:`ACU_EXT_LSB];
    assign hi = cur[`ACU_HI_MSB:`ACU_HI_LSB];
    assign lo = cur[`ACU_LO_MSB:`ACU_LO_LSB];
    // the pair is the high and low words, never limited
    assign pair_rd = {hi, lo};
    // extension reads copy its top bit into the upper twelve
    assign ext_fill = {12{ext[3]}};
    // extension bits in use when they differ from the high word sign
    assign in_use = (ext != {4{hi[15]}});
    // saturate toward the sign of the whole value
    assign limited = ext[3] ? `ACU_NEG_LIMIT : `ACU_POS_LIMIT;
    // low half of the 32-bit full scale value
    assign lim_lo = ext[3] ? 16'h0000 : 16'hffff;
    assign size_byte = (req.size == acu_pkg::ACU_SIZE_BYTE);
    assign size_word = (req.size == acu_pkg::ACU_SIZE_WORD);
    assign size_long = (req.size == acu_pkg::ACU_SIZE_LONG);

    // upper accumulators have no ordinary ext or low access
    assign portion_blocked = req.acc[1]
        && (req.sel == acu_pkg::ACU_SEL_EXT || req.sel == acu_pkg::ACU_SEL_LOW);
    assign pair_write = req.write && req.sel == acu_pkg::ACU_SEL_LONG_PAIR;
    // a refused request changes no state and returns no data
    always_comb begin
        refuse = 1'b0;
        if (req.valid) begin
            if (portion_blocked) begin
                refuse = 1'b1;
            end
            if (pair_write) begin
                refuse = 1'b1;
            end
        end
    end
    assign do_read = req.valid && !req.write && !refuse;
    assign do_write = req.valid && req.write && !refuse;

    // whole accumulator read, limited when the extension is in use
    always_comb begin
        whole_rd = {16'h0000, hi};
        whole_lim = 1'b0;
        if (size_long) begin
            if (in_use) begin
                // long store of whole is limited to 32-bit full scale
                whole_rd = {limited, lim_lo};
                whole_lim = 1'b1;
            end else begin
                whole_rd = pair_rd;
            end
        end else begin
            if (in_use) begin
                whole_rd = {16'h0000, limited};
                whole_lim = 1'b1;
            end else begin
                whole_rd = {16'h0000, hi};
            end
        end
    end

    // read data path
    always_comb begin
        rd_next = 32'h0000_0000;
        lim_hit = 1'b0;
        unique case (req.sel)
            acu_pkg::ACU_SEL_WHOLE: begin
                rd_next = whole_rd;
                lim_hit = whole_lim;
            end
            acu_pkg::ACU_SEL_LONG_PAIR: begin
                rd_next = pair_rd;
            end
            acu_pkg::ACU_SEL_EXT: begin
                rd_next = {16'h0000, ext_fill, ext};
            end
            acu_pkg::ACU_SEL_HIGH: begin
                if (size_byte) begin
                    rd_next = {24'h00_0000, hi[7:0]};
                end else begin
                    rd_next = {16'h0000, hi};
                end
            end
            acu_pkg::ACU_SEL_LOW: begin
                rd_next = {16'h0000, lo};
            end
            default: begin
                rd_next = 32'h0000_0000;
            end
        endcase
    end

    // byte fill is the sign, or zero on an unsigned move
    assign byte_fill = req.data[7] && !req.unsigned_move;

    // whole accumulator write with sign or zero extension
    always_comb begin
        if (size_long) begin
            // long into pair, extension sign filled
            whole_wr = {{4{req.data[31]}}, req.data[31:0]};
        end else if (size_word) begin
            whole_wr = {{4{req.data[15]}}, req.data[15:0], 16'h0000};
        end else begin
            // byte into low 8 bits of high word, low cleared
            whole_wr = {{12{byte_fill}}, req.data[7:0], 16'h0000};
        end
    end

    // write value for the move path
    always_comb begin
        wr_val = cur;
        unique case (req.sel)
            acu_pkg::ACU_SEL_WHOLE: begin
                wr_val = whole_wr;
            end
            acu_pkg::ACU_SEL_EXT: begin
                wr_val = {req.data[3:0], cur[31:0]};
            end
            acu_pkg::ACU_SEL_HIGH: begin
                wr_val = {ext, req.data[15:0], lo};
            end
            acu_pkg::ACU_SEL_LOW: begin
                wr_val = {ext, hi, req.data[15:0]};
            end
            default: begin
                wr_val = cur;
            end
        endcase
    end

    // accumulator storage, a move write beats an alu result
    // four 36-bit accumulators
    genvar gi;
    generate
        for (gi = 0; gi < `ACU_NUM_ACC; gi = gi + 1) begin : g_acc
            // one select bit per accumulator
            assign mv_hit[gi] = do_write && (req.acc == 2'(gi));
            assign alu_hit[gi] = alu_wr.valid && (alu_wr.acc == 2'(gi));
            always_ff @(posedge core_clk or negedge rstn) begin
                if (!rstn) begin
                    acc_reg[gi] <= `ACU_ACC_RESET;
                end else if (mv_hit[gi]) begin
                    acc_reg[gi] <= wr_val;
                end else if (alu_hit[gi]) begin
                    acc_reg[gi] <= alu_wr.value;
                end
            end
        end
    endgenerate

    // answer pulses one cycle after the request, refusals never read_valid
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            read_valid <= 1'b0;
            req_refused <= 1'b0;
        end else begin
            read_valid <= do_read;
            req_refused <= refuse;
        end
    end

    // read data holds until the next accepted read
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            core_read_data_bus <= 32'h0000_0000;
        end else if (do_read) begin
            core_read_data_bus <= rd_next;
        end
    end

    // operands never pass through the limiter
    // full 36 bits, no limiting
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            alu_operand_whole <= `ACU_ACC_RESET;
        end else begin
            alu_operand_whole <= acc_reg[operand_sel];
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            alu_operand_high <= 16'h0000;
        end else begin
            alu_operand_high <= acc_reg[operand_sel][`ACU_HI_MSB:`ACU_HI_LSB];
        end
    end

    // alu result reaching past bit 31
    assign res_in_use = alu_wr.value[35:32] != {4{alu_wr.value[31]}};

    // status flags have no clear path, there is no register access
    // extension in use flag, sticky until reset
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            ext_in_use <= 1'b0;
        end else if (alu_wr.valid && res_in_use) begin
            ext_in_use <= 1'b1;
        end
    end

    // limit flag, set by a limited transfer, sticky until reset
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            limit_flag <= 1'b0;
        end else if (do_read && lim_hit) begin
            limit_flag <= 1'b1;
        end
    end
endmodule

//--- bench/acu_monitor.sv
// port checker for the accumulator access unit
// assumes it is bound to acu_core and sees only its ports
`timescale 1ns/1ps
module acu_monitor (
    input wire logic core_clk,
    input wire logic rstn,
    input wire acu_pkg::acu_req_t req,
    input wire acu_pkg::acu_alu_wr_t alu_wr,
    input wire logic [1:0] operand_sel,
    input wire logic [31:0] core_read_data_bus,
    input wire logic read_valid,
    input wire logic req_refused,
    input wire logic [35:0] alu_operand_whole,
    input wire logic [15:0] alu_operand_high,
    input wire logic ext_in_use,
    input wire logic limit_flag
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rstn);
    wire logic rd = req.valid && !req.write;
    wire logic upper = req.valid && req.acc[1];
    a_read_answers: assert property (rd |=> read_valid ^ req_refused)
        else $error("read got no single answer");
    a_write_silent: assert property (req.valid && req.write |=> !read_valid)
        else $error("write produced read data");
    a_pair_write_refused: assert property (
        req.valid && req.write && req.sel == acu_pkg::ACU_SEL_LONG_PAIR |=> req_refused)
        else $error("pair write not refused");
    a_upper_portion_refused: assert property (
        upper && (req.sel == acu_pkg::ACU_SEL_EXT || req.sel == acu_pkg::ACU_SEL_LOW)
        |=> req_refused && !read_valid)
        else $error("upper accumulator portion reachable");
    a_ext_read_sign: assert property (
        rd && !req.acc[1] && req.sel == acu_pkg::ACU_SEL_EXT |=> core_read_data_bus
        == {16'h0, {12{core_read_data_bus[3]}}, core_read_data_bus[3:0]})
        else $error("extension read not sign extended");
    a_limit_value: assert property (
        rd && req.sel == acu_pkg::ACU_SEL_WHOLE && req.size == acu_pkg::ACU_SIZE_WORD
        ##1 $rose(limit_flag) |-> core_read_data_bus inside {32'h7fff, 32'h8000})
        else $error("limited word not full scale");
    a_limit_sticky: assert property (limit_flag |=> limit_flag)
        else $error("limit flag dropped");
    a_ext_sticky: assert property (ext_in_use |=> ext_in_use)
        else $error("extension flag dropped");
    a_operand_high: assert property (alu_operand_high == alu_operand_whole[31:16])
        else $error("high operand differs from whole");
endmodule
bind acu_core acu_monitor mon_u (.core_clk, .rstn, .req, .alu_wr, .operand_sel,
    .core_read_data_bus, .read_valid, .req_refused, .alu_operand_whole,
    .alu_operand_high, .ext_in_use, .limit_flag);

//--- bench/acu_alu_model.sv
// behavioural arithmetic result source writing whole accumulators
// assumes the bench raises go for one cycle per result
`timescale 1ns/1ps
module acu_alu_model (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic go,
    input wire logic [1:0] acc,
    input wire logic [35:0] value,
    output acu_pkg::acu_alu_wr_t alu_wr
);
    // idle cycles carry inverted data so stale values are never trusted
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            alu_wr <= '0;
        end else begin
            alu_wr <= '{go, acc, go ? value : ~value};
        end
    end
endmodule

//--- bench/testbench.sv
// random move and result traffic against a reference accumulator model
// assumes acu_core with its bound checker and the result source model
`timescale 1ns/1ps
module testbench;
    logic core_clk = 1'b0;
    logic rstn = 1'b0;
    acu_pkg::acu_req_t req = '0;
    acu_pkg::acu_alu_wr_t alu_wr;
    logic [1:0] operand_sel = 2'h0;
    logic [31:0] core_read_data_bus;
    logic read_valid, req_refused, ext_in_use, limit_flag;
    logic [35:0] alu_operand_whole;
    logic [15:0] alu_operand_high;
    logic alu_go = 1'b0;
    logic [1:0] alu_acc = 2'h0;
    logic [35:0] alu_val = 36'h0;
    logic [35:0] m [4] = '{default: 36'h0};
    logic [32:0] q [$];
    logic eu = 1'b0, lf = 1'b0;
    int failures = 0, tests_run = 0;
    initial forever #5 core_clk = ~core_clk;
    acu_alu_model alu_u (.core_clk, .rstn, .go(alu_go), .acc(alu_acc), .value(alu_val), .alu_wr);
    acu_core dut_u (.core_clk, .rstn, .req, .alu_wr, .operand_sel, .core_read_data_bus,
        .read_valid, .req_refused, .alu_operand_whole, .alu_operand_high, .ext_in_use,
        .limit_flag);
    task chk(input logic [35:0] got, input logic [35:0] exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task stop_test;
        $display("checks %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // sel 0 whole 1 pair 2 ext 3 high 4 low; size 0 byte 1 word 2 long
    task step(input logic w, input logic [1:0] a, input logic [2:0] s, input logic [1:0] z,
              input logic u, input logic [31:0] d);
        logic [35:0] v;
        logic iu;
        v = m[a];
        iu = v[35:32] != {4{v[31]}};
        @(posedge core_clk);
        req <= '{1'b1, w, a, acu_pkg::acu_sel_t'(s), acu_pkg::acu_size_t'(z), u, d};
        if ((a[1] && (s == 3'd2 || s == 3'd4)) || (w && s == 3'd1)) q.push_back({1'b1, 32'h0});
        else if (w) begin
            case (s)
                3'd0: m[a] = z == 2'd0 ? {{12{d[7] & !u}}, d[7:0], 16'h0} :
                    z == 2'd1 ? {{4{d[15]}}, d[15:0], 16'h0} : {{4{d[31]}}, d};
                3'd2: m[a][35:32] = d[3:0];
                3'd3: m[a][31:16] = d[15:0];
                default: m[a][15:0] = d[15:0];
            endcase
        end else begin
            lf |= iu && s == 3'd0;
            case (s)
                3'd0: q.push_back({1'b0, z == 2'd2 ? (iu ? {v[35], {31{!v[35]}}} : v[31:0]) :
                    {16'h0, iu ? {v[35], {15{!v[35]}}} : v[31:16]}});
                3'd1: q.push_back({1'b0, v[31:0]});
                3'd2: q.push_back({17'h0, {12{v[35]}}, v[35:32]});
                3'd3: q.push_back(z == 2'd0 ? {25'h0, v[23:16]} : {17'h0, v[31:16]});
                default: q.push_back({17'h0, v[15:0]});
            endcase
        end
    endtask
    task alu(input logic [1:0] a, input logic [35:0] v);
        @(posedge core_clk);
        req <= '0;
        alu_go <= 1'b1;
        alu_acc <= a;
        alu_val <= v;
        m[a] = v;
        eu |= v[35:32] != {4{v[31]}};
        @(posedge core_clk);
        alu_go <= 1'b0;
        repeat (2) @(posedge core_clk);
    endtask
    always @(negedge core_clk) begin
        if (read_valid === 1'b1 || req_refused === 1'b1) begin
            if (q.size() == 0) chk(36'h1, 36'h0);
            else chk({3'h0, req_refused, req_refused ? 32'h0 : core_read_data_bus},
                {3'h0, q.pop_front()});
        end
    end
    initial begin
        #100000;
        failures++;
        stop_test;
    end
    initial begin
        logic [1:0] a, z;
        logic [2:0] s;
        logic w;
        int r;
        r = $urandom(32'hb0d7e588);
        repeat (16) @(posedge core_clk);
        rstn <= 1'b1;
        repeat (400) begin
            a = 2'($urandom);
            s = 3'($urandom % 5);
            w = 1'($urandom);
            z = s == 0 ? (w ? 2'($urandom % 3) : 2'(1 + $urandom % 2)) : s == 1 ? 2'h2 :
                (s == 3 && !w) ? 2'($urandom % 2) : 2'h1;
            if ($urandom % 6 == 0) alu(a, {4'($urandom), 32'($urandom)});
            else step(w, a, s, z, 1'($urandom) & (s == 0 && w && z == 0), $urandom);
        end
        @(posedge core_clk);
        req <= '0;
        for (int i = 0; i < 4; i++) begin
            @(posedge core_clk);
            operand_sel <= 2'(i);
            repeat (3) @(posedge core_clk);
            #1 chk(alu_operand_whole, m[i]);
            chk({20'h0, alu_operand_high}, {20'h0, m[i][31:16]});
        end
        chk({34'h0, ext_in_use, limit_flag}, {34'h0, eu, lf});
        chk({4'h0, 32'(q.size())}, 36'h0);
        stop_test;
    end
endmodule
